// ===== rtl/uart_cfg_map.svh
// Register offsets, field positions, reset values and counts of the serial port block
`ifndef UART_CFG_MAP_SVH
`define UART_CFG_MAP_SVH

// Byte offsets on the I/O bus
`define OFF_DATA_PORT      10'h3f8
`define OFF_ENABLE_PORT    10'h3f9
`define OFF_CAUSE_PORT     10'h3fa
`define OFF_FORMAT         10'h3fb
`define OFF_HANDSHAKE_OUT  10'h3fc
`define OFF_LINK_COND      10'h3fd
`define OFF_HANDSHAKE_IN   10'h3fe
`define OFF_SCRATCH        10'h3ff

// Frame format control fields
`define FMT_DIV_ACCESS_BIT 7
`define FMT_BREAK_BIT      6
`define FMT_STICK_BIT      5
`define FMT_EVEN_BIT       4
`define FMT_PARITY_BIT     3
`define FMT_STOP_BIT       2

// Queue control fields
`define QCTL_ENABLE_BIT    0
`define QCTL_RX_CLEAR_BIT  1
`define QCTL_TX_CLEAR_BIT  2
`define QCTL_DMA_MODE_BIT  3

// Handshake output control fields
`define HOC_READY_BIT      0
`define HOC_REQUEST_BIT    1
`define HOC_AUX1_BIT       2
`define HOC_INT_GATE_BIT   3

// Interrupt source enable fields
`define IEN_RX_BIT         0
`define IEN_THRE_BIT       1
`define IEN_LINE_BIT       2
`define IEN_MODEM_BIT      3

// Reset values
`define RST_BYTE           8'h00
`define RST_DIVISOR        16'h0000

// Queue depth and receive trigger levels
`define QUEUE_DEPTH        5'h10
`define QUEUE_DEPTH_LEGACY 5'h01
`define TRIG_LEVEL_0       5'h01
`define TRIG_LEVEL_1       5'h04
`define TRIG_LEVEL_2       5'h08
`define TRIG_LEVEL_3       5'h0e

`endif

// ===== rtl/uart_cfg_pkg.sv
// Types shared by the serial port block
`default_nettype none
package uart_cfg_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [4:0] level_t;
    // Interrupt cause codes in priority order, shown in the low nibble
    typedef enum logic [3:0] {
        CAUSE_LINE  = 4'h6,
        CAUSE_RX    = 4'h4,
        CAUSE_THRE  = 4'h2,
        CAUSE_MODEM = 4'h0,
        CAUSE_NONE  = 4'h1
    } int_cause_t;
endpackage
`default_nettype wire

// ===== rtl/baud_divider.sv
// Programmable divider making the 16x bit-rate tick
`timescale 1ns/1ps
`default_nettype none
`include "uart_cfg_map.svh"

module baud_divider (
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic [15:0] divisor,
    input  wire logic        reload,
    output var  logic        tick
);
    logic [15:0] count;
    logic        reload_due;

    // Reload one cycle late, so the byte just written is already in the divisor
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            reload_due <= 1'b0;
        end
        else
        begin
            reload_due <= reload;
        end
    end

    // Count down from the divisor; a zero divisor stops the ticks
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            count <= `RST_DIVISOR;
            tick  <= 1'b0;
        end
        else if (reload_due || divisor == 16'h0000)
        begin
            count <= divisor;
            tick  <= 1'b0;
        end
        else if (count <= 16'h0001)
        begin
            count <= divisor;
            tick  <= 1'b1;
        end
        else
        begin
            count <= count - 16'h0001;
            tick  <= 1'b0;
        end
    end
endmodule // baud_divider

`default_nettype wire

// ===== rtl/fifo_uart_regs.sv
// Host register file, queues and interrupt logic of the serial port
`timescale 1ns/1ps
`default_nettype none
`include "uart_cfg_map.svh"

module fifo_uart_regs (
    input  wire logic       CLK,
    input  wire logic       SRST,
    input  wire logic [9:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output var  logic [7:0] RDATA,
    input  wire logic [7:0] RX_DATA,
    input  wire logic       RX_VALID,
    input  wire logic       RX_PARITY_ERR,
    input  wire logic       RX_FRAME_ERR,
    input  wire logic       RX_BREAK,
    output var  logic [7:0] TX_DATA,
    output var  logic       TX_VALID,
    input  wire logic       TX_TAKE,
    input  wire logic       CTS_N,
    input  wire logic       DSR_N,
    input  wire logic       RI_N,
    input  wire logic       DCD_N,
    output var  logic       BAUD_TICK,
    output var  logic [7:0] FORMAT,
    output var  logic       RTS_N,
    output var  logic       DTR_N,
    output var  logic       AUX1_N,
    output var  logic       INT_GATE_N,
    output var  logic       INTR,
    output var  logic       RXRDY_N,
    output var  logic       TXRDY_N
);
    uart_cfg_pkg::byte_t      ien;
    uart_cfg_pkg::byte_t      hoc;
    uart_cfg_pkg::byte_t      scratch;
    uart_cfg_pkg::byte_t      div_lo;
    uart_cfg_pkg::byte_t      div_hi;
    uart_cfg_pkg::byte_t      rx_mem [16];
    uart_cfg_pkg::byte_t      tx_mem [16];
    uart_cfg_pkg::level_t     rx_count;
    uart_cfg_pkg::level_t     tx_count;
    uart_cfg_pkg::level_t     next_rx_count;
    uart_cfg_pkg::level_t     next_tx_count;
    uart_cfg_pkg::level_t     limit;
    uart_cfg_pkg::int_cause_t cause;
    logic [3:0] rx_rd;
    logic [3:0] rx_wr;
    logic [3:0] tx_rd;
    logic [3:0] tx_wr;
    logic [3:0] next_tx_rd;
    logic [1:0] trig_sel;
    logic [3:0] line_flags;
    logic [3:0] modem_delta;
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [3:0] pin_prev;
    logic       fifo_en;
    logic       dma_mode;
    logic       thre_flag;
    logic       burst_rx;
    logic       divisor_access;
    logic       rd_data;
    logic       wr_data;
    logic       rd_cause;
    logic       wr_queue;
    logic       rx_push;
    logic       rx_pop;
    logic       tx_push;
    logic       tx_pop;
    logic       rx_clear;
    logic       tx_clear;
    logic       rx_trig;
    logic       int_pending;
    logic       div_write;

    // Receive trigger depth for the two select bits
    function automatic uart_cfg_pkg::level_t trig_depth(input logic [1:0] sel);
        case (sel)
            2'b00:   trig_depth = `TRIG_LEVEL_0;
            2'b01:   trig_depth = `TRIG_LEVEL_1;
            2'b10:   trig_depth = `TRIG_LEVEL_2;
            default: trig_depth = `TRIG_LEVEL_3;
        endcase
    endfunction

    // True for a host access at a given offset
    function automatic logic hit(input logic strobe, input logic [9:0] off);
        hit = strobe && (ADDR == off);
    endfunction

    // Access decode; the divisor bit steals the two low offsets
    assign divisor_access = FORMAT[`FMT_DIV_ACCESS_BIT];
    assign rd_data  = hit(RD, `OFF_DATA_PORT) && !divisor_access;
    assign wr_data  = hit(WR, `OFF_DATA_PORT) && !divisor_access;
    assign rd_cause = hit(RD, `OFF_CAUSE_PORT);
    assign wr_queue = hit(WR, `OFF_CAUSE_PORT);
    assign div_write = divisor_access
                    && (hit(WR, `OFF_DATA_PORT) || hit(WR, `OFF_ENABLE_PORT));

    // Without the queues each side holds one byte, as the legacy part did
    assign limit    = fifo_en ? `QUEUE_DEPTH : `QUEUE_DEPTH_LEGACY;
    assign rx_push  = RX_VALID && (rx_count < limit);
    assign rx_pop   = rd_data && (rx_count != 5'h00);
    assign tx_push  = wr_data && (tx_count < limit);
    assign tx_pop   = TX_TAKE && TX_VALID;
    // Clearing on any change of the enable bit avoids stale bytes
    assign rx_clear = wr_queue && (WDATA[`QCTL_RX_CLEAR_BIT]
                    || (WDATA[`QCTL_ENABLE_BIT] != fifo_en));
    assign tx_clear = wr_queue && (WDATA[`QCTL_TX_CLEAR_BIT]
                    || (WDATA[`QCTL_ENABLE_BIT] != fifo_en));
    assign next_rx_count = rx_clear ? 5'h00 : rx_count
                         + {4'h0, rx_push} - {4'h0, rx_pop};
    assign next_tx_count = tx_clear ? 5'h00 : tx_count
                         + {4'h0, tx_push} - {4'h0, tx_pop};
    assign next_tx_rd = tx_clear ? tx_wr : tx_rd + {3'h0, tx_pop};

    // Plain control registers written by the host
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            FORMAT  <= `RST_BYTE;
            ien     <= `RST_BYTE;
            hoc     <= `RST_BYTE;
            scratch <= `RST_BYTE;
            div_lo  <= `RST_BYTE;
            div_hi  <= `RST_BYTE;
        end
        else if (WR)
        begin
            case (ADDR)
                `OFF_DATA_PORT:     if (divisor_access) div_lo <= WDATA;
                `OFF_ENABLE_PORT:   if (divisor_access) div_hi <= WDATA;
                                    else ien <= {4'h0, WDATA[3:0]};
                `OFF_FORMAT:        FORMAT <= WDATA;
                `OFF_HANDSHAKE_OUT: hoc <= {3'h0, WDATA[4:0]};
                `OFF_SCRATCH:       scratch <= WDATA;
                default:            scratch <= scratch;
            endcase
        end
    end

    // Queue control; reserved bits 5:4 are never stored
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            fifo_en  <= 1'b0;
            dma_mode <= 1'b0;
            trig_sel <= 2'b00;
        end
        else if (wr_queue)
        begin
            fifo_en  <= WDATA[`QCTL_ENABLE_BIT];
            dma_mode <= WDATA[`QCTL_DMA_MODE_BIT];
            trig_sel <= WDATA[7:6];
        end
    end

    // Receive queue storage and pointers
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            rx_rd    <= 4'h0;
            rx_wr    <= 4'h0;
            rx_count <= 5'h00;
        end
        else
        begin
            if (rx_push)
            begin
                rx_mem[rx_wr] <= RX_DATA;
            end
            rx_wr    <= rx_clear ? 4'h0 : rx_wr + {3'h0, rx_push};
            rx_rd    <= rx_clear ? 4'h0 : rx_rd + {3'h0, rx_pop};
            rx_count <= next_rx_count;
        end
    end

    // Transmit queue; head byte is presented from a register
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            tx_rd    <= 4'h0;
            tx_wr    <= 4'h0;
            tx_count <= 5'h00;
            TX_DATA  <= `RST_BYTE;
            TX_VALID <= 1'b0;
        end
        else
        begin
            if (tx_push)
            begin
                tx_mem[tx_wr] <= WDATA;
            end
            tx_wr    <= tx_wr + {3'h0, tx_push && !tx_clear};
            tx_rd    <= next_tx_rd;
            tx_count <= next_tx_count;
            TX_VALID <= next_tx_count != 5'h00;
            // Bypass when the byte lands in the slot being presented
            TX_DATA  <= (tx_push && next_tx_rd == tx_wr) ? WDATA : tx_mem[next_tx_rd];
        end
    end

    // Line status events stick until read; a new event beats the clear
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            line_flags <= 4'h0;
        end
        else
        begin
            line_flags <= (hit(RD, `OFF_LINK_COND) ? 4'h0 : line_flags)
                        | {RX_BREAK, RX_FRAME_ERR, RX_PARITY_ERR,
                           RX_VALID && !rx_push};
        end
    end

    // Handshake pins are asynchronous: two flops before any use
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            pin_meta <= 4'hf;
            pin_sync <= 4'hf;
            pin_prev <= 4'hf;
        end
        else
        begin
            pin_meta <= {DCD_N, RI_N, DSR_N, CTS_N};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Modem change flags; ring flag only on the trailing edge of ring
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            modem_delta <= 4'h0;
        end
        else
        begin
            modem_delta <= (hit(RD, `OFF_HANDSHAKE_IN) ? 4'h0 : modem_delta)
                         | {pin_sync[3] ^ pin_prev[3], pin_sync[2] & ~pin_prev[2],
                            pin_sync[1] ^ pin_prev[1], pin_sync[0] ^ pin_prev[0]};
        end
    end

    // Transmit-empty flag: set when the queue drains, cleared by a write
    // or by reading the cause while it is the one shown
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            thre_flag <= 1'b0;
        end
        else if ((tx_count != 5'h00 && next_tx_count == 5'h00)
                 || (hit(WR, `OFF_ENABLE_PORT) && !divisor_access
                     && WDATA[`IEN_THRE_BIT] && !ien[`IEN_THRE_BIT]
                     && tx_count == 5'h00))
        begin
            thre_flag <= 1'b1;
        end
        else if (tx_push || (rd_cause && cause == uart_cfg_pkg::CAUSE_THRE))
        begin
            thre_flag <= 1'b0;
        end
    end

    // Highest-priority enabled cause
    assign rx_trig = fifo_en ? (rx_count >= trig_depth(trig_sel))
                             : (rx_count != 5'h00);
    always_comb
    begin
        if (ien[`IEN_LINE_BIT] && line_flags != 4'h0)
            cause = uart_cfg_pkg::CAUSE_LINE;
        else if (ien[`IEN_RX_BIT] && rx_trig)
            cause = uart_cfg_pkg::CAUSE_RX;
        else if (ien[`IEN_THRE_BIT] && thre_flag)
            cause = uart_cfg_pkg::CAUSE_THRE;
        else if (ien[`IEN_MODEM_BIT] && modem_delta != 4'h0)
            cause = uart_cfg_pkg::CAUSE_MODEM;
        else
            cause = uart_cfg_pkg::CAUSE_NONE;
    end
    assign int_pending = cause != uart_cfg_pkg::CAUSE_NONE;

    // Burst request mode latches on the trigger and holds until empty
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            burst_rx <= 1'b0;
        end
        else if (next_rx_count == 5'h00)
        begin
            burst_rx <= 1'b0;
        end
        else if (rx_trig)
        begin
            burst_rx <= 1'b1;
        end
    end

    // Output pins; the interrupt is a level, never a per-event pulse
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            INTR       <= 1'b0;
            DTR_N      <= 1'b1;
            RTS_N      <= 1'b1;
            AUX1_N     <= 1'b1;
            INT_GATE_N <= 1'b1;
            RXRDY_N    <= 1'b1;
            TXRDY_N    <= 1'b0;
        end
        else
        begin
            INTR       <= int_pending;
            DTR_N      <= !hoc[`HOC_READY_BIT];
            RTS_N      <= !hoc[`HOC_REQUEST_BIT];
            AUX1_N     <= !hoc[`HOC_AUX1_BIT];
            INT_GATE_N <= !hoc[`HOC_INT_GATE_BIT];
            if (fifo_en && dma_mode)
            begin
                RXRDY_N <= !burst_rx;
                TXRDY_N <= tx_count == `QUEUE_DEPTH;
            end
            else
            begin
                RXRDY_N <= rx_count == 5'h00;
                TXRDY_N <= tx_count != 5'h00;
            end
        end
    end

    // Read data, valid the cycle after the read strobe
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            RDATA <= `RST_BYTE;
        end
        else if (RD)
        begin
            case (ADDR)
                `OFF_DATA_PORT:     RDATA <= divisor_access ? div_lo : rx_mem[rx_rd];
                `OFF_ENABLE_PORT:   RDATA <= divisor_access ? div_hi : ien;
                `OFF_CAUSE_PORT:    RDATA <= {fifo_en, fifo_en, 2'b00, cause};
                `OFF_FORMAT:        RDATA <= FORMAT;
                `OFF_HANDSHAKE_OUT: RDATA <= hoc;
                `OFF_LINK_COND:     RDATA <= {fifo_en && line_flags[3:1] != 3'h0,
                                              tx_count == 5'h00 && !TX_VALID,
                                              tx_count == 5'h00, line_flags,
                                              rx_count != 5'h00};
                `OFF_HANDSHAKE_IN:  RDATA <= {~pin_sync, modem_delta};
                `OFF_SCRATCH:       RDATA <= scratch;
                default:            RDATA <= `RST_BYTE;
            endcase
        end
    end

    // Bit-rate generator reloads whenever a divisor byte is written
    baud_divider u_baud (
        .CLK     (CLK),
        .SRST    (SRST),
        .divisor ({div_hi, div_lo}),
        .reload  (div_write),
        .tick    (BAUD_TICK)
    );
endmodule // fifo_uart_regs

`default_nettype wire

// ===== sim/fifo_uart_regs_sva.sv
// Port checker for the serial port register block
`timescale 1ns/1ps
`default_nettype none
module fifo_uart_regs_sva (
    input wire logic       CLK,
    input wire logic       SRST,
    input wire logic [9:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic [7:0] TX_DATA,
    input wire logic       TX_VALID,
    input wire logic       BAUD_TICK,
    input wire logic [7:0] FORMAT,
    input wire logic       INT_GATE_N,
    input wire logic       INTR
);
    logic qen;
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    // Queue enable as last written; the port gives no other view of it
    always_ff @(posedge CLK)
    begin
        if (SRST)
            qen <= 1'b0;
        else if (WR && ADDR == 10'h3fa)
            qen <= WDATA[0];
    end
    a_format_load:
        assert property (WR && ADDR == 10'h3fb |=> FORMAT == $past(WDATA))
        else $error("Format register missed a write");
    a_gate_set:
        assert property (WR && ADDR == 10'h3fc && WDATA[3] |=> ##1 !INT_GATE_N)
        else $error("Interrupt gate pin not driven");
    a_tx_head:
        assert property (WR && ADDR == 10'h3f8 && !FORMAT[7] && !TX_VALID
            |=> TX_VALID && TX_DATA == $past(WDATA))
        else $error("Transmit byte not presented");
    a_cause_mode:
        assert property (RD && ADDR == 10'h3fa |=> RDATA[7:6] == {2{$past(qen)}})
        else $error("Cause bits 7:6 wrong for queue mode");
    a_unmapped_read:
        assert property (RD && ADDR[9:3] != 7'h7f |=> RDATA == 8'h00)
        else $error("Unmapped read returned data");
    a_rdata_hold:
        assert property (!RD |=> $stable(RDATA))
        else $error("Read data changed without a read");
    a_tick_period:
        assert property (BAUD_TICK && !FORMAT[7] |=> !BAUD_TICK [*5] ##1 BAUD_TICK)
        else $error("Tick spacing differs from divisor six");
    a_intr_off:
        assert property (WR && ADDR == 10'h3f9 && !FORMAT[7] && WDATA[3:0] == 4'h0
            |-> ##[1:3] !INTR)
        else $error("Interrupt stayed up with all sources off");
endmodule // fifo_uart_regs_sva
bind fifo_uart_regs fifo_uart_regs_sva chk_u (
    .CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .BAUD_TICK(BAUD_TICK),
    .FORMAT(FORMAT), .INT_GATE_N(INT_GATE_N), .INTR(INTR)
);
`default_nettype wire

// ===== sim/io_host_model.sv
// Host processor model issuing byte-wide I/O bus cycles
`timescale 1ns/1ps
`default_nettype none
module io_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output var  logic [9:0] addr,
    output var  logic [7:0] wdata,
    output var  logic       wr,
    output var  logic       rd
);
    // Idle bus at time zero
    initial
    begin
        addr = 10'h000;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // One-cycle strobe; released lines show the inverse, never stale values
    task automatic bus_wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
    endtask
    // Registered answer is taken one edge after the strobe
    task automatic bus_rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        @(posedge clk);
        #1;
        d = rdata;
    endtask
endmodule // io_host_model
`default_nettype wire

// ===== sim/fifo_uart_regs_tb.sv
// Self-checking bench for the serial port register block
`timescale 1ns/1ps
`default_nettype none
module fifo_uart_regs_tb;
    logic       clk, srst, wr, rd, rx_valid, par_err, tx_take, cts_n;
    logic       tx_valid, tick, rts_n, dtr_n, aux1_n, gate_n, intr, rxrdy_n, txrdy_n;
    logic [9:0] addr;
    logic [7:0] wdata, rdata, rx_data, tx_data, format;
    int         failures, cmp_count;
    // Frame error, break and three modem pins stay inactive
    fifo_uart_regs dut_u (
        .CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .RX_DATA(rx_data), .RX_VALID(rx_valid),
        .RX_PARITY_ERR(par_err), .RX_FRAME_ERR(1'b0), .RX_BREAK(1'b0),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_TAKE(tx_take), .CTS_N(cts_n),
        .DSR_N(1'b1), .RI_N(1'b1), .DCD_N(1'b1), .BAUD_TICK(tick), .FORMAT(format),
        .RTS_N(rts_n), .DTR_N(dtr_n), .AUX1_N(aux1_n), .INT_GATE_N(gate_n),
        .INTR(intr), .RXRDY_N(rxrdy_n), .TXRDY_N(txrdy_n)
    );
    io_host_model host_u (
        .clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd)
    );
    // 250 MHz clock
    always #2 clk = ~clk;
    // Byte and bit comparisons, all counted
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    // Bus shorthands and settle waits
    task automatic wreg(input logic [9:0] a, input logic [7:0] d);
        host_u.bus_wr(a, d);
    endtask
    task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.bus_rd(a, d);
        chk8(d, exp);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rx_push(input logic [7:0] d);
        @(posedge clk);
        rx_data <= d;
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
    endtask
    // Cycles up to the next tick, capped so a dead divider cannot hang
    task automatic next_tick(output int n);
        n = 0;
        do
        begin
            wait_cyc(1);
            n++;
        end
        while (tick !== 1'b1 && n < 20);
    endtask
    // Legacy state straight after reset
    task automatic t_reset;
        rchk(10'h3fa, 8'h01);
        rchk(10'h3f9, 8'h00);
        chk1(gate_n, 1'b1);
        chk1(txrdy_n, 1'b0);
        $display("reset test done");
    endtask
    // Divisor through the remapped offsets, then frame format
    task automatic t_init;
        int n;
        wreg(10'h3fb, 8'h80);
        wreg(10'h3f8, 8'h06);
        wreg(10'h3f9, 8'h00);
        rchk(10'h3f8, 8'h06);
        wreg(10'h3fb, 8'h1a);
        chk8(format, 8'h1a);
        rchk(10'h3f9, 8'h00);
        rchk(10'h3f7, 8'h00);
        wreg(10'h3ff, 8'ha5);
        rchk(10'h3ff, 8'ha5);
        next_tick(n);
        next_tick(n);
        chk8(8'(n), 8'h06);
        $display("init test done");
    endtask
    // Trigger level, reserved bits, request mode, clears and auto-clear
    task automatic t_queue;
        wreg(10'h3fa, 8'hc1);
        rchk(10'h3fa, 8'hc1);
        wreg(10'h3f9, 8'h01);
        for (int i = 0; i < 13; i++)
            rx_push(8'(i));
        wait_cyc(3);
        chk1(intr, 1'b0);
        rx_push(8'h0d);
        wait_cyc(3);
        chk1(intr, 1'b1);
        wait_cyc(6);
        rchk(10'h3fa, 8'hc4);
        wreg(10'h3fa, 8'hf3);
        wait_cyc(3);
        chk1(intr, 1'b0);
        rx_push(8'h3c);
        wait_cyc(3);
        chk1(rxrdy_n, 1'b0);
        chk1(intr, 1'b0);
        wreg(10'h3fa, 8'hcb);
        rx_push(8'h3d);
        wait_cyc(3);
        chk1(rxrdy_n, 1'b1);
        wreg(10'h3f8, 8'h55);
        wreg(10'h3f8, 8'h66);
        @(posedge clk);
        tx_take <= 1'b1;
        @(posedge clk);
        tx_take <= 1'b0;
        wait_cyc(1);
        chk8(tx_data, 8'h66);
        chk1(txrdy_n, 1'b0);
        wreg(10'h3fa, 8'hc5);
        chk1(tx_valid, 1'b0);
        wreg(10'h3fa, 8'h00);
        rx_push(8'h11);
        wreg(10'h3f8, 8'h77);
        wreg(10'h3fa, 8'h01);
        wait_cyc(1);
        chk1(tx_valid, 1'b0);
        rchk(10'h3fd, 8'h60);
        $display("queue test done");
    endtask
    // Sources, read-to-clear status and the interrupt gate pin
    task automatic t_status;
        logic [7:0] d;
        wreg(10'h3f9, 8'h0f);
        rchk(10'h3f9, 8'h0f);
        chk1(intr, 1'b1);
        rchk(10'h3fa, 8'hc2);
        wait_cyc(2);
        chk1(intr, 1'b0);
        @(posedge clk);
        par_err <= 1'b1;
        @(posedge clk);
        par_err <= 1'b0;
        rchk(10'h3fa, 8'hc6);
        host_u.bus_rd(10'h3fd, d);
        chk8(d & 8'h7f, 8'h64);
        host_u.bus_rd(10'h3fd, d);
        chk8(d & 8'h7f, 8'h60);
        @(posedge clk);
        cts_n <= 1'b0;
        wait_cyc(6);
        rchk(10'h3fe, 8'h11);
        rchk(10'h3fe, 8'h10);
        wreg(10'h3fc, 8'h08);
        wait_cyc(1);
        chk1(gate_n, 1'b0);
        chk1(rts_n, 1'b1);
        chk1(dtr_n, 1'b1);
        chk1(aux1_n, 1'b1);
        wreg(10'h3fc, 8'h07);
        wait_cyc(1);
        chk1(gate_n, 1'b1);
        chk8({5'h00, aux1_n, rts_n, dtr_n}, 8'h00);
        wreg(10'h3f9, 8'h00);
        wait_cyc(3);
        chk1(intr, 1'b0);
        $display("status test done");
    endtask
    // Verdict and end of run
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence; inputs change only on the rising edge
    initial
    begin
        clk = 1'b0;
        srst = 1'b1;
        {rx_valid, par_err, tx_take, cts_n} = 4'h1;
        rx_data = 8'h00;
        failures = 0;
        cmp_count = 0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_init();
        t_queue();
        t_status();
        close_out();
    end
    // Tests need well under a thousand cycles; this cuts a hang short
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        close_out();
    end
endmodule // fifo_uart_regs_tb
`default_nettype wire
